// file: rtl/ecs_access.sv
// eprom access and protection: serial programming port, cpu special reads,
// power-up configuration latch and security-bit gating
// assumes main code eprom lies outside and answers code_vfy_data combinationally
// How it works
// (RULE_01) two-pin serial commands, addresses, data
// (RULE_02) three signature bytes readable by programmer
// (RULE_03) program reads signatures via code read
// (RULE_04) customer 32 bytes readable via code read
// (RULE_05) customer area answers data reads only
// (RULE_06) customer area programmed in same session
// (RULE_07) config latched at power-up, then frozen
// (RULE_08) config bytes are eprom, programmed serially
// (RULE_09) program reads config via external data read
// (RULE_10) both bits erased: program and verify
// (RULE_11) first bit set: only second bit programmable
// (RULE_12) both bits set: verify refused too
// (RULE_13) programmer never sets second bit alone
// (RULE_14) decode first config byte into features
module ecs_access
  import ecs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        nv_erase_n,
  input  wire logic        prog_mode_pin,
  input  wire logic        prog_clk_pin,
  input  wire logic        prog_data_i,
  output logic             prog_data_o,
  output logic             prog_data_oe,
  output logic             prog_refused,
  output logic             code_prog_we,
  output logic [15:0]      code_addr,
  output logic [7:0]       code_prog_data,
  input  wire logic [7:0]  code_vfy_data,
  input  wire logic        cpu_code_rd,
  input  wire logic [15:0] cpu_code_addr,
  output logic [7:0]       cpu_code_data,
  output logic             cpu_code_hit,
  input  wire logic        cpu_xdata_rd,
  input  wire logic [15:0] cpu_xdata_addr,
  output logic [7:0]       cpu_xdata_data,
  output logic             cpu_xdata_hit,
  output ecs_cfg_s         cfg,
  output logic             cfg_valid,
  output logic [1:0]       lock_state
);
  ecs_state_e  state_q;
  ecs_frame_s  frame_q;
  logic [4:0]  cnt_q;
  logic [7:0]  out_sr_q;
  logic        pmode_lvl, pclk_lvl, pdata_lvl, pclk_prev_q, pclk_rise;
  logic [7:0]  cfg1_val, cfg2_val;
  logic        sb1_val, sb2_val;
  logic [1:0]  sec;
  logic        in_exec, is_prog, is_sig, in_cust, refuse;
  logic        cust_we, cfg1_we, cfg2_we, sb1_we, sb2_we;
  logic [7:0]  rd_byte, cust_peek;
  logic [7:0]  cust_mem [CUST_BYTES];

  ecs_sync3 #(.RST_VAL(1'b0)) u_sync_mode (
    .clk     (clk),
    .resetn  (resetn),
    .async_i (prog_mode_pin),
    .level_o (pmode_lvl)
  );
  ecs_sync3 #(.RST_VAL(1'b0)) u_sync_clk (
    .clk     (clk),
    .resetn  (resetn),
    .async_i (prog_clk_pin),
    .level_o (pclk_lvl)
  );
  ecs_sync3 #(.RST_VAL(1'b0)) u_sync_data (
    .clk     (clk),
    .resetn  (resetn),
    .async_i (prog_data_i),
    .level_o (pdata_lvl)
  );

  // (RULE_08) config bytes held as eprom cells
  ecs_nv_cell #(.W(8)) u_cfg1 (
    .clk       (clk),
    .erase_n   (nv_erase_n),
    .prog_we   (cfg1_we),
    .prog_data (frame_q.data),
    .value_o   (cfg1_val)
  );
  ecs_nv_cell #(.W(8)) u_cfg2 (
    .clk       (clk),
    .erase_n   (nv_erase_n),
    .prog_we   (cfg2_we),
    .prog_data (frame_q.data),
    .value_o   (cfg2_val)
  );
  ecs_nv_cell #(.W(1)) u_sb1 (
    .clk       (clk),
    .erase_n   (nv_erase_n),
    .prog_we   (sb1_we),
    .prog_data (1'b0),
    .value_o   (sb1_val)
  );
  ecs_nv_cell #(.W(1)) u_sb2 (
    .clk       (clk),
    .erase_n   (nv_erase_n),
    .prog_we   (sb2_we),
    .prog_data (1'b0),
    .value_o   (sb2_val)
  );

  assign sec        = {sb2_val, sb1_val};
  assign lock_state = sec;
  assign pclk_rise  = pclk_lvl & ~pclk_prev_q;
  assign in_exec    = (state_q == ST_EXEC);
  assign is_prog    = (frame_q.cmd == CMD_PROG);
  assign is_sig     = (frame_q.addr == SIG_A_ADDR) || (frame_q.addr == SIG_B_ADDR) ||
                      (frame_q.addr == SIG_C_ADDR);
  assign in_cust    = (frame_q.addr >= CUST_BASE) && (frame_q.addr <= CUST_LAST);
  assign cust_peek  = cust_mem[cpu_code_addr[CUST_AW-1:0]];
  // (RULE_06) programming targets in one session
  assign cust_we = in_exec && is_prog && (sec == SEC_OPEN) && in_cust;
  assign cfg1_we = in_exec && is_prog && (sec == SEC_OPEN) && (frame_q.addr == CFG1_ADDR);
  assign cfg2_we = in_exec && is_prog && (sec == SEC_OPEN) && (frame_q.addr == CFG2_ADDR);
  assign sb1_we  = in_exec && (frame_q.cmd == CMD_PROG_SB1) && (sec == SEC_OPEN);
  // (RULE_11) second bit only after first
  assign sb2_we  = in_exec && (frame_q.cmd == CMD_PROG_SB2) && (sec == SEC_NO_PROG);
  // (RULE_10) gating of each command
  always_comb begin
    unique case (frame_q.cmd)
      CMD_PROG:     refuse = (sec != SEC_OPEN);
      CMD_VERIFY:   refuse = (sec == SEC_LOCKED) && !is_sig;
      CMD_PROG_SB1: refuse = (sec != SEC_OPEN);
      CMD_PROG_SB2: refuse = (sec != SEC_NO_PROG);
      default:      refuse = 1'b1;
    endcase
  end
  // (RULE_02) signature bytes always readable
  always_comb begin
    if (frame_q.addr == SIG_A_ADDR) begin
      rd_byte = SIG_A_VAL;
    end else if (frame_q.addr == SIG_B_ADDR) begin
      rd_byte = SIG_B_VAL;
    end else if (frame_q.addr == SIG_C_ADDR) begin
      rd_byte = SIG_C_VAL;
    // (RULE_12) verify blocked when locked
    end else if (sec == SEC_LOCKED) begin
      rd_byte = LOCKED_BYTE;
    end else if (in_cust) begin
      rd_byte = cust_mem[frame_q.addr[CUST_AW-1:0]];
    end else if (frame_q.addr == CFG1_ADDR) begin
      rd_byte = cfg1_val;
    end else if (frame_q.addr == CFG2_ADDR) begin
      rd_byte = cfg2_val;
    end else if (frame_q.addr <= CODE_LAST) begin
      rd_byte = code_vfy_data;
    end else begin
      rd_byte = ERASED_BYTE;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pclk_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_lvl;
    end
  end

  // (RULE_01) serial frame engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      frame_q      <= '0;
      cnt_q        <= '0;
      out_sr_q     <= '0;
      prog_data_oe <= 1'b0;
      prog_refused <= 1'b0;
    end else if (!pmode_lvl) begin
      state_q      <= ST_IDLE;
      cnt_q        <= '0;
      prog_data_oe <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_SHIFT;
          cnt_q   <= '0;
        end
        ST_SHIFT: begin
          if (pclk_rise) begin
            frame_q <= ecs_frame_s'({frame_q[FRAME_BITS-2:0], pdata_lvl});
            cnt_q   <= cnt_q + 5'h01;
            if (cnt_q == FRAME_LAST) begin
              state_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          prog_refused <= refuse;
          cnt_q        <= '0;
          state_q      <= (frame_q.cmd == CMD_VERIFY) ? ST_LOAD : ST_SHIFT;
        end
        ST_LOAD: begin
          out_sr_q     <= rd_byte;
          prog_data_oe <= 1'b1;
          state_q      <= ST_OUT;
        end
        ST_OUT: begin
          if (pclk_rise) begin
            out_sr_q <= {out_sr_q[6:0], 1'b0};
            cnt_q    <= cnt_q + 5'h01;
            if (cnt_q == OUT_LAST) begin
              prog_data_oe <= 1'b0;
              cnt_q        <= '0;
              state_q      <= ST_SHIFT;
            end
          end
        end
      endcase
    end
  end

  assign prog_data_o = out_sr_q[7];

  // main code eprom write and verify address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_prog_we   <= 1'b0;
      code_addr      <= '0;
      code_prog_data <= '0;
    end else begin
      code_prog_we <= in_exec && is_prog && (sec == SEC_OPEN) && (frame_q.addr <= CODE_LAST);
      if (in_exec) begin
        code_addr      <= frame_q.addr;
        code_prog_data <= frame_q.data;
      end
    end
  end
  // (RULE_06) customer bytes share the eprom erase
  always_ff @(posedge clk or negedge nv_erase_n) begin
    if (!nv_erase_n) begin
      for (int i = 0; i < CUST_BYTES; i++) begin
        cust_mem[i] <= ERASED_BYTE;
      end
    end else if (cust_we) begin
      cust_mem[frame_q.addr[CUST_AW-1:0]] <= cust_mem[frame_q.addr[CUST_AW-1:0]] & frame_q.data;
    end
  end
  // (RULE_03) code-read answers for special space
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_code_data <= '0;
      cpu_code_hit  <= 1'b0;
    end else if (cpu_code_rd) begin
      cpu_code_hit <= 1'b1;
      if (cpu_code_addr == SIG_A_ADDR) begin
        cpu_code_data <= SIG_A_VAL;
      end else if (cpu_code_addr == SIG_B_ADDR) begin
        cpu_code_data <= SIG_B_VAL;
      end else if (cpu_code_addr == SIG_C_ADDR) begin
        cpu_code_data <= SIG_C_VAL;
      // (RULE_04) customer data through code read
      end else if ((cpu_code_addr >= CUST_BASE) && (cpu_code_addr <= CUST_LAST)) begin
        cpu_code_data <= cust_peek;
      end else begin
        cpu_code_data <= '0;
        cpu_code_hit  <= 1'b0;
      end
    end else begin
      // (RULE_05) no fetch path, data reads only
      cpu_code_hit <= 1'b0;
    end
  end
  // (RULE_09) config bytes by external data read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_xdata_data <= '0;
      cpu_xdata_hit  <= 1'b0;
    end else if (cpu_xdata_rd && (cpu_xdata_addr == CFG1_ADDR)) begin
      cpu_xdata_data <= cfg1_val;
      cpu_xdata_hit  <= 1'b1;
    end else if (cpu_xdata_rd && (cpu_xdata_addr == CFG2_ADDR)) begin
      cpu_xdata_data <= cfg2_val;
      cpu_xdata_hit  <= 1'b1;
    end else begin
      cpu_xdata_data <= '0;
      cpu_xdata_hit  <= 1'b0;
    end
  end
  // (RULE_07) latch once after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg       <= '0;
      cfg_valid <= 1'b0;
    end else if (!cfg_valid) begin
      cfg_valid                 <= 1'b1;
      // (RULE_14) field decode
      cfg.watchdog_enable_cfg   <= cfg1_val[CFG_WDT_BIT];
      cfg.reset_pin_disable_cfg <= cfg1_val[CFG_RPD_BIT];
      cfg.port_reset_level_cfg  <= cfg1_val[CFG_PORT_RESET_LEVEL_CFG_BIT];
      cfg.brownout_voltage_cfg  <= cfg1_val[CFG_BOV_BIT];
      cfg.clock_rate_cfg        <= cfg1_val[CFG_CLOCK_RATE_CFG_BIT];
      cfg.oscillator_select_cfg <= cfg1_val[CFG_OSC_MSB:CFG_OSC_LSB];
      cfg.external_clock        <= (cfg1_val[CFG_OSC_MSB:CFG_OSC_LSB] == OSC_EXT_CLK);
    end
  end

  AST_CFG_FROZEN: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
    cfg_valid && $past(cfg_valid) |-> $stable(cfg))
    else $error("config changed after power-up latch");
  AST_CFG_DECODE: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
    !cfg_valid ##1 cfg_valid |-> cfg.watchdog_enable_cfg == $past(cfg1_val[CFG_WDT_BIT]) &&
      cfg.external_clock == ($past(cfg1_val[CFG_OSC_MSB:CFG_OSC_LSB]) == OSC_EXT_CLK))
    else $error("config decode mismatch");
  AST_SIG_READ: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
    cpu_code_rd && (cpu_code_addr == SIG_C_ADDR) |=> cpu_code_hit && cpu_code_data == SIG_C_VAL)
    else $error("signature read wrong");
  AST_CUST_READ: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
    cpu_code_rd && (cpu_code_addr >= CUST_BASE) && (cpu_code_addr <= CUST_LAST)
    |=> cpu_code_hit && cpu_code_data == $past(cust_peek))
    else $error("customer read wrong");
  AST_XDATA_CFG: assert property (@(posedge clk) disable iff (!resetn) // RULE_09
    cpu_xdata_rd && (cpu_xdata_addr == CFG1_ADDR) |=> cpu_xdata_hit && cpu_xdata_data == $past(cfg1_val))
    else $error("config byte read wrong");
  AST_PROG_OPEN: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
    in_exec && is_prog && sec == SEC_OPEN && frame_q.addr <= CODE_LAST |=> code_prog_we ##1 !code_prog_we)
    else $error("open part did not program");
  AST_PROG_LOCK: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
    in_exec && is_prog && !sb1_val |=> !code_prog_we && prog_refused && $stable(cfg1_val))
    else $error("programming accepted while protected");
  AST_VFY_LOCK: assert property (@(posedge clk) disable iff (!resetn) // RULE_12
    state_q == ST_LOAD && pmode_lvl && sec == SEC_LOCKED && !is_sig
    |=> out_sr_q == LOCKED_BYTE && prog_data_oe)
    else $error("verify leaked data while locked");
  AST_SER_OUT: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
    state_q == ST_EXEC && frame_q.cmd == CMD_VERIFY && pmode_lvl |=> state_q == ST_LOAD ##1 prog_data_oe)
    else $error("verify answer not driven");
  AST_SEC_STATE: assert property (@(posedge clk) disable iff (!resetn || !nv_erase_n) // RULE_13
    sec != SEC_BAD)
    else $error("unsupported security state");
endmodule // ecs_access

// file: rtl/ecs_pkg.sv
// package for the eprom configuration and security access block
// assumes a single 200 MHz clock domain; serial pins arrive asynchronous
package ecs_pkg;

  // cpu-visible addresses of the special eprom bytes
  localparam logic [15:0] SIG_A_ADDR = 16'hFC30;
  localparam logic [15:0] SIG_B_ADDR = 16'hFC31;
  localparam logic [15:0] SIG_C_ADDR = 16'hFC60;
  localparam logic [15:0] CUST_BASE  = 16'hFCE0;
  localparam logic [15:0] CUST_LAST  = 16'hFCFF;
  localparam logic [15:0] CFG1_ADDR  = 16'hFD00;
  localparam logic [15:0] CFG2_ADDR  = 16'hFD01;
  localparam logic [15:0] CODE_LAST  = 16'h07FF;

  // signature contents: arbitrary values
  localparam logic [7:0]  SIG_A_VAL  = 8'h15;
  localparam logic [7:0]  SIG_B_VAL  = 8'h2A;
  localparam logic [7:0]  SIG_C_VAL  = 8'h3C;

  localparam int          CUST_BYTES = 32;
  localparam int          CUST_AW    = 5;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [7:0]  LOCKED_BYTE = 8'h00;

  // first configuration byte fields
  localparam int          CFG_WDT_BIT  = 7;
  localparam int          CFG_RPD_BIT  = 6;
  localparam int          CFG_PORT_RESET_LEVEL_CFG_BIT = 5;
  localparam int          CFG_BOV_BIT  = 4;
  localparam int          CFG_CLOCK_RATE_CFG_BIT = 3;
  localparam int          CFG_OSC_MSB  = 2;
  localparam int          CFG_OSC_LSB  = 0;
  localparam logic [2:0]  OSC_EXT_CLK  = 3'h7;

  // serial commands
  localparam logic [7:0]  CMD_PROG     = 8'h01;
  localparam logic [7:0]  CMD_VERIFY   = 8'h02;
  localparam logic [7:0]  CMD_PROG_SB1 = 8'h03;
  localparam logic [7:0]  CMD_PROG_SB2 = 8'h04;

  localparam int          FRAME_BITS = 32;
  localparam logic [4:0]  FRAME_LAST = 5'h1F;
  localparam logic [4:0]  OUT_LAST   = 5'h07;

  // security state as {security_bit_two, security_bit_one}
  localparam logic [1:0]  SEC_OPEN    = 2'h3;
  localparam logic [1:0]  SEC_NO_PROG = 2'h2;
  localparam logic [1:0]  SEC_BAD     = 2'h1;
  localparam logic [1:0]  SEC_LOCKED  = 2'h0;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } ecs_frame_s;

  typedef struct packed {
    logic       watchdog_enable_cfg;
    logic       reset_pin_disable_cfg;
    logic       port_reset_level_cfg;
    logic       brownout_voltage_cfg;
    logic       clock_rate_cfg;
    logic [2:0] oscillator_select_cfg;
    logic       external_clock;
  } ecs_cfg_s;

  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_EXEC, ST_LOAD, ST_OUT} ecs_state_e;

endpackage : ecs_pkg

// file: rtl/ecs_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes async_i is an unsynchronised pin level
module ecs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_q, s2_q, s3_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level follows only when second and third stage agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_o <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule // ecs_sync3

// file: rtl/ecs_nv_cell.sv
// one programmable eprom cell group: erase sets ones, programming clears bits
// assumes erase_n models the uv erase of the array
module ecs_nv_cell #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         erase_n,
  input  wire logic         prog_we,
  input  wire logic [W-1:0] prog_data,
  output logic      [W-1:0] value_o
);
  always_ff @(posedge clk or negedge erase_n) begin
    if (!erase_n) begin
      value_o <= '1;
    end else if (prog_we) begin
      value_o <= value_o & prog_data;
    end
  end
endmodule // ecs_nv_cell

// file: tb/ecs_prog_model.sv
// programming system model: mode pin, serial clock, shared data wire
// assumes the device drives prog_data_o while prog_data_oe is high
module ecs_prog_model
  import ecs_pkg::*;
(
  input  wire logic clk,
  input  wire logic dev_data,
  input  wire logic dev_oe,
  output logic      prog_mode_pin,
  output logic      prog_clk_pin,
  output logic      prog_data_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_q;
  assign prog_data_line = dev_oe ? dev_data : drv_q;
  initial begin
    prog_mode_pin = 1'b0;
    prog_clk_pin  = 1'b0;
    drv_q         = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic enter();
    hold(1);
    prog_mode_pin <= 1'b1;
    hold(20);
  endtask
  // frame out msb first, then readout on verify
  task automatic frame(input ecs_frame_s f, output logic [7:0] q);
    logic [31:0] bits;
    bits = f;
    q = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      hold(1);
      drv_q <= bits[i];
      hold(8);
      prog_clk_pin <= 1'b1;
      hold(10);
      prog_clk_pin <= 1'b0;
    end
    hold(1);
    drv_q <= ~drv_q;
    hold(20);
    if (f.cmd == CMD_VERIFY) begin
      for (int i = 0; i < 8; i++) begin
        #1;
        q = {q[6:0], prog_data_line};
        hold(1);
        prog_clk_pin <= 1'b1;
        hold(10);
        prog_clk_pin <= 1'b0;
        hold(10);
      end
    end
  endtask
endmodule // ecs_prog_model

// file: tb/tb_eprom_config_security_access.sv
// self-checking bench for ecs_access with programmer and code eprom models
// assumes a 200 MHz clock and erase applied with reset at time zero
module tb_eprom_config_security_access
  import ecs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, nv_erase_n, prog_mode_pin, prog_clk_pin, prog_data_line;
  logic prog_data_o, prog_data_oe, prog_refused, code_prog_we, cfg_valid;
  logic cpu_code_rd, cpu_code_hit, cpu_xdata_rd, cpu_xdata_hit;
  logic [15:0] code_addr, cpu_code_addr, cpu_xdata_addr;
  logic [7:0]  code_prog_data, code_vfy_data, cpu_code_data, cpu_xdata_data, q;
  logic [1:0]  lock_state;
  ecs_cfg_s    cfg;
  logic [7:0]  code_mem [0:2047];
  int          n_errors, samples_checked, n_we;

  ecs_access ecs_access_inst (
    .clk(clk), .resetn(resetn), .nv_erase_n(nv_erase_n), .prog_mode_pin(prog_mode_pin),
    .prog_clk_pin(prog_clk_pin), .prog_data_i(prog_data_line), .prog_data_o(prog_data_o),
    .prog_data_oe(prog_data_oe), .prog_refused(prog_refused), .code_prog_we(code_prog_we),
    .code_addr(code_addr), .code_prog_data(code_prog_data), .code_vfy_data(code_vfy_data),
    .cpu_code_rd(cpu_code_rd), .cpu_code_addr(cpu_code_addr), .cpu_code_data(cpu_code_data),
    .cpu_code_hit(cpu_code_hit), .cpu_xdata_rd(cpu_xdata_rd), .cpu_xdata_addr(cpu_xdata_addr),
    .cpu_xdata_data(cpu_xdata_data), .cpu_xdata_hit(cpu_xdata_hit), .cfg(cfg),
    .cfg_valid(cfg_valid), .lock_state(lock_state));
  ecs_prog_model ecs_prog_model_inst (
    .clk(clk), .dev_data(prog_data_o), .dev_oe(prog_data_oe), .prog_mode_pin(prog_mode_pin),
    .prog_clk_pin(prog_clk_pin), .prog_data_line(prog_data_line));

  // main code eprom: erased ones, programming clears bits
  initial foreach (code_mem[i]) code_mem[i] = ERASED_BYTE;
  always @(posedge clk) begin
    if (code_prog_we === 1'b1) begin
      code_mem[code_addr[10:0]] <= code_mem[code_addr[10:0]] & code_prog_data;
      n_we <= n_we + 1;
    end
  end
  assign code_vfy_data = code_mem[code_addr[10:0]];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic ecs_cfg_s exp_cfg(input logic [7:0] b);
    return {b, b[2:0] == OSC_EXT_CLK};
  endfunction
  task automatic cpu_rd(input logic xd, input logic [15:0] a, input logic [8:0] exp);
    @(posedge clk);
    cpu_code_rd <= ~xd;
    cpu_xdata_rd <= xd;
    cpu_code_addr <= a;
    cpu_xdata_addr <= a;
    @(posedge clk);
    cpu_code_rd <= 1'b0;
    cpu_xdata_rd <= 1'b0;
    #1;
    if (xd) chk({cpu_xdata_hit, cpu_xdata_data}, exp);
    else chk({cpu_code_hit, cpu_code_data}, exp);
  endtask
  task automatic sframe(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    ecs_prog_model_inst.frame('{cmd: c, addr: a, data: d}, q);
  endtask
  task automatic t_power_up();
    chk(cfg_valid, 1'b1);
    chk(cfg, exp_cfg(ERASED_BYTE));
    cpu_rd(1'b1, CFG1_ADDR, {1'b1, ERASED_BYTE});
    cpu_rd(1'b0, CFG1_ADDR, 9'h000);
    $display("test power_up done");
  endtask
  task automatic t_cpu_reads();
    cpu_rd(1'b0, SIG_A_ADDR, {1'b1, SIG_A_VAL});
    cpu_rd(1'b0, SIG_B_ADDR, {1'b1, SIG_B_VAL});
    cpu_rd(1'b0, SIG_C_ADDR, {1'b1, SIG_C_VAL});
    cpu_rd(1'b0, CUST_BASE, {1'b1, ERASED_BYTE});
    cpu_rd(1'b0, CUST_LAST, {1'b1, ERASED_BYTE});
    cpu_rd(1'b0, 16'hFCDF, 9'h000);
    cpu_rd(1'b1, SIG_A_ADDR, 9'h000);
    $display("test cpu_reads done");
  endtask
  task automatic t_program();
    ecs_prog_model_inst.enter();
    sframe(CMD_PROG, 16'h0010, 8'hA5);
    chk(n_we, 1);
    chk({prog_refused, code_prog_data}, 9'h0A5);
    chk(code_addr, 16'h0010);
    sframe(CMD_VERIFY, 16'h0010, 8'h00);
    chk(q, 8'hA5);
    sframe(CMD_PROG, 16'hFCE5, 8'h5A);
    cpu_rd(1'b0, 16'hFCE5, {1'b1, 8'h5A});
    sframe(CMD_PROG, CFG1_ADDR, 8'h12);
    cpu_rd(1'b1, CFG1_ADDR, {1'b1, 8'h12});
    chk(cfg, exp_cfg(ERASED_BYTE));
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk(cfg, exp_cfg(8'h12));
    $display("test program done");
  endtask
  task automatic t_security();
    // bit one always before bit two
    sframe(CMD_PROG_SB1, 16'h0000, 8'h00);
    chk({prog_refused, lock_state}, 3'h2);
    sframe(CMD_PROG, 16'h0020, 8'h00);
    chk({prog_refused, n_we[3:0]}, 5'h11);
    sframe(CMD_PROG_SB1, 16'h0000, 8'h00);
    chk(prog_refused, 1'b1);
    sframe(CMD_VERIFY, 16'h0010, 8'h00);
    chk({prog_refused, q}, 9'h0A5);
    sframe(CMD_PROG_SB2, 16'h0000, 8'h00);
    chk({prog_refused, lock_state}, 3'h0);
    sframe(CMD_VERIFY, 16'h0010, 8'h00);
    chk({prog_refused, q}, {1'b1, LOCKED_BYTE});
    sframe(CMD_VERIFY, SIG_A_ADDR, 8'h00);
    chk(q, SIG_A_VAL);
    sframe(8'h05, 16'h0000, 8'h00);
    chk(prog_refused, 1'b1);
    $display("test security done");
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {resetn, nv_erase_n, cpu_code_rd, cpu_xdata_rd} = 4'h0;
    {cpu_code_addr, cpu_xdata_addr} = 32'h0;
    {n_errors, samples_checked, n_we} = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    nv_erase_n <= 1'b1;
    @(posedge clk);
    #1;
    t_power_up();
    t_cpu_reads();
    t_program();
    t_security();
    results();
  end
  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  end
endmodule // tb_eprom_config_security_access
